// *** logic/idle_timer_pkg.sv ***
// shared constants and types for the idle wakeup timer
package idle_timer_pkg;

  // ==========================================================================
  // counter and clocking
  localparam int           CNT_W          = 16;
  localparam int           OSC_DIV        = 5;
  localparam int           TAP_BASE_BIT   = 11;
  localparam int           TAP_SPAN       = 4;
  localparam logic [15:0]  COUNT_RESET    = 16'hffff;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0]   OFS_PERIOD_SEL = 8'h00;
  localparam logic [7:0]   OFS_INT_CTRL   = 8'h04;
  localparam logic [7:0]   OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0]   OFS_IRQ_MASK   = 8'h0c;

  // ==========================================================================
  // field layout and reset values
  localparam int           PCODE_LSB      = 0;
  localparam int           PCODE_W        = 3;
  localparam int           RESERVED_MUST_BE_ZERO_HI_LSB    = 3;
  localparam int           RESERVED_MUST_BE_ZERO_ONE_BIT   = 6;
  localparam logic [2:0]   PCODE_MAX      = 3'h4;
  localparam logic [7:0]   PERIOD_RESET   = 8'h40;
  localparam int           INT_PEND_BIT   = 5;
  localparam int           INT_EN_BIT     = 4;
  localparam int           INT_GIE_BIT    = 0;
  localparam int           IRQ_TICK_BIT   = 0;

  // ==========================================================================
  // wishbone carriers
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_s;

  // reserved codes fall back to the longest period
  function automatic logic [2:0] tap_offset(input logic [2:0] code);
    tap_offset = (code > PCODE_MAX) ? PCODE_MAX : code;
  endfunction

endpackage

// *** logic/osc_prescaler.sv ***
// divides the oscillator clock down to one instruction-cycle tick
`timescale 1ns/100ps
module osc_prescaler
#(
  parameter int DIV = idle_timer_pkg::OSC_DIV
)
(
  input  wire logic core_clk,
  input  wire logic rst_b,
  output logic      instrTick
);
  import idle_timer_pkg::*;

  // elaboration check: the phase counter is only eight bits wide
  if (DIV < 2 || DIV > 255)
  begin : g_div_range
    $error("prescaler divide out of range");
  end

  logic [7:0] phaseQ;
  logic [7:0] phaseD;
  logic       tickQ;
  wire        lastPhase = (phaseQ == 8'(DIV - 1));

  // ==========================================================================
  // phase counter
  assign phaseD = lastPhase ? 8'h00 : phaseQ + 8'h01;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      phaseQ <= 8'h00;
      tickQ  <= 1'b0;
    end
    else
    begin
      phaseQ <= phaseD;
      tickQ  <= lastPhase;
    end
  end

  assign instrTick = tickQ;

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence quietFour;
    !instrTick [*4];
  endsequence

  tick_spacing_a: assert property (instrTick |=>
      quietFour ##1 instrTick)
    else $error("instruction tick not one in five clocks");

endmodule

// *** logic/underflow_tap.sv ***
// picks the tap bit and flags the cycle in which it underflows
`timescale 1ns/100ps
module underflow_tap
(
  input  wire logic        instrTick,
  input  wire logic [15:0] count,
  input  wire logic [2:0]  periodCode,
  output logic             tapUnderflow
);
  import idle_timer_pkg::*;

  wire [2:0]  tapOfs  = tap_offset(periodCode);
  // low bits up to and including the tap, bit 11 .. bit 15
  wire [15:0] lowMask = 16'hffff >> (3'(TAP_SPAN) - tapOfs);

  // the tap bit underflows when all bits below and at it wrap from zero
  assign tapUnderflow = instrTick && ((count & lowMask) == 16'h0000);

endmodule

// *** logic/idle_wakeup_timer.sv ***
// idle wakeup timer: free-running counter, tap, flags and wishbone registers
`timescale 1ns/100ps
module idle_wakeup_timer
(
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  input  wire idle_timer_pkg::wb_req_s wbReq,
  output idle_timer_pkg::wb_rsp_s      wbRsp,
  output logic                         irq,
  output logic                         idleIrqReq,
  output logic                         portG6ClearPulse,
  output logic                         deviceResetReq,
  output logic [15:0]                  timeBase,
  output logic                         timeBaseTick
);
  import idle_timer_pkg::*;

  // ==========================================================================
  // instruction-cycle tick and idle counter
  logic        instrTick;
  logic [15:0] idleCounterQ;
  logic [15:0] idleCounterD;
  logic        tapUnderflow;

  osc_prescaler #(
    .DIV       (OSC_DIV)
  ) u_prescaler (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .instrTick (instrTick)
  );

  // free running; wrap from zero to all ones comes from the natural borrow
  assign idleCounterD = instrTick ? idleCounterQ - 16'h0001
                                  : idleCounterQ;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      idleCounterQ <= COUNT_RESET;
    else
      idleCounterQ <= idleCounterD;
  end

  // ==========================================================================
  // register state
  logic [7:0] periodSelQ;
  logic [7:0] periodSelD;
  logic       pendingQ;
  logic       pendingD;
  logic       irqEnableQ;
  logic       gieQ;
  logic [0:0] irqStatusQ;
  logic [0:0] irqStatusD;
  logic [0:0] irqMaskQ;
  logic       ackQ;
  logic [31:0] rdataQ;
  logic       reqQ;
  logic       portClearQ;
  logic       resetReqQ;
  logic       tickOutQ;

  wire [2:0] periodCode = periodSelQ[PCODE_LSB +: PCODE_W];

  underflow_tap u_tap (
    .instrTick    (instrTick),
    .count        (idleCounterQ),
    .periodCode   (periodCode),
    .tapUnderflow (tapUnderflow)
  );

  // ==========================================================================
  // wishbone decode
  wire        busReq    = wbReq.cyc && wbReq.stb && !ackQ;
  wire        wrLane    = busReq && wbReq.we && wbReq.sel[0];
  wire [7:0]  wrByte    = wbReq.dat[7:0];
  wire        hitPeriod = (wbReq.adr == OFS_PERIOD_SEL);
  wire        hitIntCtl = (wbReq.adr == OFS_INT_CTRL);
  wire        hitStatus = (wbReq.adr == OFS_IRQ_STATUS);
  wire        hitMask   = (wbReq.adr == OFS_IRQ_MASK);
  wire        wrPeriod  = wrLane && hitPeriod;
  wire        wrIntCtl  = wrLane && hitIntCtl;
  wire        wrStatus  = wrLane && hitStatus;
  wire        wrMask    = wrLane && hitMask;

  // legacy software writing zero to the high reserved bits forces a reset
  wire        badHigh   = (wrByte[7:RESERVED_MUST_BE_ZERO_HI_LSB] == 5'h00);
  wire        selfReset = wrPeriod && badHigh;

  // reserved bits are kept as written; software is trusted to follow
  assign periodSelD = (wrPeriod && !badHigh) ? wrByte : periodSelQ;

  // pending: writing one to bit 5 clears it, an underflow in the same cycle
  // still wins so no event is lost
  wire pendClear = wrIntCtl && wrByte[INT_PEND_BIT];
  assign pendingD = tapUnderflow ? 1'b1
                                 : (pendingQ && !pendClear);

  wire statClear = wrStatus && wrByte[IRQ_TICK_BIT];
  assign irqStatusD[0] = tapUnderflow ? 1'b1
                                      : (irqStatusQ[0] && !statClear);

  wire [7:0] intCtlRead =
      {2'b00, pendingQ, irqEnableQ, 3'b000, gieQ};

  wire [31:0] readMux =
      hitPeriod ? {24'h000000, periodSelQ} :
      hitIntCtl ? {24'h000000, intCtlRead} :
      hitStatus ? {31'h00000000, irqStatusQ} :
      hitMask   ? {31'h00000000, irqMaskQ} :
                  32'h00000000;

  // ==========================================================================
  // registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      periodSelQ <= PERIOD_RESET;
      pendingQ   <= 1'b0;
      irqEnableQ <= 1'b0;
      gieQ       <= 1'b0;
      irqStatusQ <= 1'b0;
      irqMaskQ   <= 1'b0;
    end
    else
    begin
      periodSelQ <= periodSelD;
      pendingQ   <= pendingD;
      irqStatusQ <= irqStatusD;
      if (wrIntCtl)
      begin
        irqEnableQ <= wrByte[INT_EN_BIT];
        gieQ       <= wrByte[INT_GIE_BIT];
      end
      if (wrMask)
        irqMaskQ <= wrByte[IRQ_TICK_BIT];
    end
  end

  // ==========================================================================
  // bus answer and event outputs
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ackQ       <= 1'b0;
      rdataQ     <= 32'h00000000;
      reqQ       <= 1'b0;
      portClearQ <= 1'b0;
      resetReqQ  <= 1'b0;
      tickOutQ   <= 1'b0;
    end
    else
    begin
      ackQ       <= busReq;
      rdataQ     <= busReq ? readMux : 32'h00000000;
      reqQ       <= pendingQ && irqEnableQ && gieQ;
      portClearQ <= tapUnderflow;
      resetReqQ  <= selfReset;
      tickOutQ   <= instrTick;
    end
  end

  assign wbRsp.ack        = ackQ;
  assign wbRsp.dat        = rdataQ;
  assign idleIrqReq       = reqQ;
  assign portG6ClearPulse = portClearQ;
  assign deviceResetReq   = resetReqQ;
  // watchdog and halt start-up logic share this count rather than own timers
  assign timeBase         = idleCounterQ;
  assign timeBaseTick     = tickOutQ;
  assign irq              = |(irqStatusQ & irqMaskQ);

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence periodWrite;
    busReq && wbReq.we && wbReq.sel[0] && hitPeriod;
  endsequence

  sequence pendClearWrite;
    busReq && wbReq.we && wbReq.sel[0] && hitIntCtl
      && wbReq.dat[INT_PEND_BIT];
  endsequence

  sequence tapEvent;
    tapUnderflow;
  endsequence

  // pending and the wakeup pulse appear together; the pulse lasts one cycle
  sequence wakeStep;
    pendingQ && portG6ClearPulse ##1 !portG6ClearPulse;
  endsequence

  sequence busTake;
    busReq;
  endsequence

  sequence answerStep;
    wbRsp.ack ##1 !wbRsp.ack;
  endsequence

  count_step_a: assert property (instrTick |=>
      idleCounterQ == $past(idleCounterQ) - 16'h0001)
    else $error("idle counter did not step on tick");

  count_hold_a: assert property (!instrTick |=> $stable(idleCounterQ))
    else $error("idle counter moved without a tick");

  count_wrap_a: assert property (instrTick
      && idleCounterQ == 16'h0000 |=> idleCounterQ == 16'hffff)
    else $error("idle counter did not wrap to all ones");

  tap_zero_a: assert property (tapUnderflow |->
      idleCounterQ[TAP_BASE_BIT - 1:0] == 11'h000)
    else $error("tap fired with low bits not zero");

  pend_set_a: assert property (tapEvent |=> wakeStep)
    else $error("underflow did not raise pending");

  port_clear_a: assert property (tapUnderflow |=> portG6ClearPulse)
    else $error("port clear pulse missing after underflow");

  pend_sticky_a: assert property (pendingQ && !pendClear
      |=> pendingQ)
    else $error("pending dropped without a clear");

  irq_request_a: assert property (pendingQ && irqEnableQ && gieQ
      |=> idleIrqReq)
    else $error("interrupt request missing");

  irq_gate_a: assert property (idleIrqReq |->
      $past(gieQ) && $past(pendingQ))
    else $error("interrupt request without its enables");

  reset_period_a: assert property ($rose(rst_b)
      |-> periodCode == 3'h0)
    else $error("period code not cleared by reset");

  bad_write_a: assert property (periodWrite
      ##0 wbReq.dat[7:3] == 5'h00 |=> deviceResetReq && $stable(periodSelQ))
    else $error("zero high bits did not request reset");

  good_write_a: assert property (periodWrite
      ##0 wbReq.dat[7:3] != 5'h00 |=> periodSelQ == $past(wbReq.dat[7:0]))
    else $error("period select write lost");

  ack_single_a: assert property (wbRsp.ack |=> !wbRsp.ack)
    else $error("ack held longer than one cycle");

  bus_answer_a: assert property (busTake |=> answerStep)
    else $error("bus take not answered by a one-cycle ack");

  idle_data_a: assert property (!wbRsp.ack |-> wbRsp.dat == 32'h00000000)
    else $error("read data not zero outside ack");

  read_period_a: assert property (busReq && !wbReq.we && hitPeriod
      |=> wbRsp.dat == {24'h000000, $past(periodSelQ)})
    else $error("period select read back wrong");

  period_hold_a: assert property (!wrPeriod |=> $stable(periodSelQ))
    else $error("period select changed without a write");

  pend_clear_a: assert property (pendClearWrite ##0 !tapUnderflow
      |=> !pendingQ)
    else $error("pending not cleared by software");

  status_set_a: assert property (tapEvent |=> irqStatusQ[0])
    else $error("underflow did not set status");

  irq_enable_a: assert property (idleIrqReq |-> $past(irqEnableQ))
    else $error("interrupt request without its enable");

  port_only_a: assert property (portG6ClearPulse |->
      $past(tapUnderflow))
    else $error("port clear pulse without an underflow");

  reset_only_a: assert property (deviceResetReq |->
      $past(selfReset))
    else $error("reset request without a bad write");

  base_tick_a: assert property (timeBaseTick == $past(instrTick))
    else $error("time base tick not one cycle after the tick");

  tap_fire_a: assert property (instrTick && periodCode == 3'h0
      && idleCounterQ[11:0] == 12'h000 |-> tapUnderflow)
    else $error("tap bit 11 underflow missed");

endmodule

// *** tb/port_g_model.sv ***
// far-side model of port G data bit 6 as the core sees it
`timescale 1ns/100ps
module port_g_model
(
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic setBit,
  input  wire logic clearPulse,
  output logic      portG6
);
  // ==========================================================================
  // port bit: the core sets it before idling, the wakeup pulse knocks it down
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      portG6 <= 1'b0;
    else if (clearPulse)
      portG6 <= 1'b0;
    else if (setBit)
      portG6 <= 1'b1;
  end
endmodule

// *** tb/tb_idle_wakeup_timer.sv ***
// self-checking bench for the idle wakeup timer
`timescale 1ns/100ps
module tb_idle_wakeup_timer;
  import idle_timer_pkg::*;
  logic          core_clk = 1'b0;
  logic          rst_b = 1'b0;
  wb_req_s       wbReq = '0;
  wb_rsp_s       wbRsp;
  logic          irq, idleIrqReq, portG6ClearPulse, deviceResetReq;
  logic [15:0]   timeBase;
  logic          timeBaseTick, portG6;
  logic          setBit = 1'b0;
  logic [31:0]   rd;
  logic [15:0]   tbA, tbB;
  longint        t0, t1;
  longint        cycCnt = 0;
  int            errorCnt = 0;
  int            comparisons = 0;
  int            rstCnt = 0;

  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (deviceResetReq === 1'b1) rstCnt++;
  // spans are counted in clock cycles, free of time rounding
  always @(posedge core_clk) cycCnt <= cycCnt + 1;

  idle_wakeup_timer i_idle_wakeup_timer (.core_clk(core_clk), .rst_b(rst_b),
    .wbReq(wbReq), .wbRsp(wbRsp), .irq(irq), .idleIrqReq(idleIrqReq),
    .portG6ClearPulse(portG6ClearPulse), .deviceResetReq(deviceResetReq),
    .timeBase(timeBase), .timeBaseTick(timeBaseTick));
  port_g_model i_port_g_model (.core_clk(core_clk), .rst_b(rst_b),
    .setBit(setBit), .clearPulse(portG6ClearPulse), .portG6(portG6));

  // ==========================================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; the master waits for ack however long it takes, only the watchdog ends it
  task automatic bus(input logic we, input logic [7:0] adr,
                     input logic [31:0] wd, output logic [31:0] q);
    @(posedge core_clk);
    wbReq <= '{1'b1, 1'b1, we, adr, 4'hf, wd};
    do @(posedge core_clk); while (wbRsp.ack !== 1'b1);
    q = wbRsp.dat;
    wbReq <= '0;
    @(posedge core_clk);
  endtask

  // edge-sampled so values seen are those the design held in the pulse cycle
  task automatic waitp(output longint t, output logic [15:0] tb);
    do @(posedge core_clk); while (portG6ClearPulse !== 1'b1);
    t = cycCnt;
    tb = timeBase;
  endtask

  task automatic tick(output longint t, output logic [15:0] tb);
    do @(posedge core_clk); while (timeBaseTick !== 1'b1);
    t = cycCnt;
    tb = timeBase;
  endtask

  task automatic results;
    if (errorCnt == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================================
  // tests
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    bus(1'b0, OFS_PERIOD_SEL, 32'h0, rd);
    chk(rd, 32'h40);
    bus(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b0, OFS_INT_CTRL, 32'h0, rd);
    chk(rd, 32'h0);
    for (int c = 4; c >= 0; c--)
    begin
      bus(1'b1, OFS_PERIOD_SEL, 32'h40 | c, rd);
      bus(1'b0, OFS_PERIOD_SEL, 32'h0, rd);
      chk(rd, 32'h40 | c);
    end
    // period changes may raise a stray event, so flush it first
    bus(1'b1, OFS_INT_CTRL, 32'h21, rd);
    bus(1'b1, OFS_IRQ_STATUS, 32'h1, rd);
    chk(irq, 1'b0);
    bus(1'b1, OFS_IRQ_MASK, 32'h1, rd);
    bus(1'b1, OFS_INT_CTRL, 32'h11, rd);
    tick(t0, tbA);
    tick(t1, tbB);
    chk(tbB, tbA - 16'h1);
    chk(t1 - t0, OSC_DIV);
    setBit <= 1'b1;
    @(posedge core_clk);
    setBit <= 1'b0;
    @(posedge core_clk);
    chk(portG6, 1'b1);
    waitp(t0, tbA);
    chk(irq, 1'b1);
    // the request is registered one cycle behind the pending flag
    @(posedge core_clk);
    chk(idleIrqReq, 1'b1);
    chk(portG6, 1'b0);
    bus(1'b0, OFS_INT_CTRL, 32'h0, rd);
    chk(rd, 32'h31);
    waitp(t1, tbB);
    chk(t1 - t0, 4096 * OSC_DIV);
    bus(1'b0, OFS_INT_CTRL, 32'h0, rd);
    chk(rd, 32'h31);
    bus(1'b1, OFS_INT_CTRL, 32'h21, rd);
    bus(1'b0, OFS_INT_CTRL, 32'h0, rd);
    chk(rd, 32'h01);
    chk(idleIrqReq, 1'b0);
    bus(1'b1, OFS_IRQ_STATUS, 32'h1, rd);
    chk(irq, 1'b0);
    bus(1'b1, OFS_PERIOD_SEL, 32'h01, rd);
    chk(rstCnt, 1);
    bus(1'b0, OFS_PERIOD_SEL, 32'h0, rd);
    chk(rd, 32'h40);
    bus(1'b1, OFS_PERIOD_SEL, 32'h41, rd);
    waitp(t0, tbA);
    chk(tbA[12:0], 13'h1fff);
    results();
  end

  // about 82k cycles of tests; give a margin before calling it a hang
  initial
  begin
    #(95000 * 5);
    errorCnt++;
    results();
  end
endmodule
